// ---- hdl/iam_pkg.sv ----
// Constants and types shared by the access control entry matcher.
package iam_pkg;
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_PROTO_VAL = 8'h04;
    localparam logic [7:0]  OFS_SRC_ADDR  = 8'h08;
    localparam logic [7:0]  OFS_SRC_MASK  = 8'h0C;
    localparam logic [7:0]  OFS_DST_ADDR  = 8'h10;
    localparam logic [7:0]  OFS_DST_MASK  = 8'h14;
    localparam logic [7:0]  OFS_COUNT     = 8'h18;
    localparam logic [7:0]  OFS_STATUS    = 8'h1C;
    localparam int unsigned ADDR_LSB      = 2;
    localparam int unsigned ADDR_MSB      = 7;

    // Field positions in the control register.
    localparam int unsigned CTRL_FTYPE    = 0;
    localparam int unsigned CTRL_PROTO_LO = 1;
    localparam int unsigned CTRL_TTL_LO   = 4;
    localparam int unsigned CTRL_FRAG_LO  = 6;
    localparam int unsigned CTRL_OPT_LO   = 8;
    localparam int unsigned CTRL_SRC_LO   = 10;
    localparam int unsigned CTRL_DST_LO   = 12;
    localparam int unsigned CTRL_WIDTH    = 14;

    // Reset values.
    localparam logic [13:0] CTRL_RST      = 14'h0000;
    localparam logic [7:0]  PROTO_RST     = 8'h00;
    localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
    localparam logic [31:0] MASK_RST      = 32'h0000_0000;
    localparam logic [31:0] COUNT_RST     = 32'h0000_0000;

    // Well-known IPv4 protocol numbers.
    localparam logic [7:0]  PROTO_ICMP    = 8'h01;
    localparam logic [7:0]  PROTO_TCP     = 8'h06;
    localparam logic [7:0]  PROTO_UDP     = 8'h11;

    // Protocol filter selection.
    typedef enum logic [2:0] {
        PM_ANY      = 3'h0,
        PM_SPECIFIC = 3'h1,
        PM_ICMP     = 3'h2,
        PM_UDP      = 3'h3,
        PM_TCP      = 3'h4
    } iam_proto_mode_t;

    // Three-way flag setting shared by time-to-live, fragment and options.
    typedef enum logic [1:0] {
        TM_ANY = 2'h0,
        TM_NO  = 2'h1,
        TM_YES = 2'h2
    } iam_tri_mode_t;

    // Address filter selection.
    typedef enum logic [1:0] {
        AM_ANY     = 2'h0,
        AM_HOST    = 2'h1,
        AM_NETWORK = 2'h2
    } iam_addr_mode_t;
endpackage : iam_pkg

// ---- hdl/iam_matcher.sv ----
// Matching logic and AHB-Lite register file for one IPv4 access control entry.
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - IPv4 settings only apply when the entry's frame type selection is IPv4.
// - Protocol filter any ignores the protocol field.
// - Specific protocol filter matches only the configured 8-bit protocol value.
// - ICMP selection needs protocol ICMP and passing ICMP sub-parameters.
// - UDP selection needs protocol UDP and passing UDP sub-parameters.
// - TCP selection needs protocol TCP and passing TCP sub-parameters.
// - Time-to-live setting is zero, non-zero or any; any ignores it.
// - Setting zero refuses frames whose time-to-live exceeds zero.
// - Setting non-zero lets frames with time-to-live above zero match.
// - Fragmented means more-fragments set or fragment offset above zero.
// - Fragment no rejects fragmented, yes requires fragmented, any ignores it.
// - Options setting no refuses frames with the options flag set.
// - Options yes requires the flag set; any ignores the flag.
// - Source filter any ignores the source address.
// - Source filter host needs an exact source address match.
// - Source filter network compares only bits selected by the source mask.
// - Destination filter network compares only bits selected by the destination mask.
// - A per-entry counter counts frames that matched the entry.
module iam_matcher (
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire logic        FRM_VALID_I,
    input  wire logic        FRM_IS_IPV4_I,
    input  wire logic [7:0]  FRM_PROTO_I,
    input  wire logic [7:0]  FRM_TTL_I,
    input  wire logic        FRM_MORE_FRAG_I,
    input  wire logic [12:0] FRM_FRAGMENT_OFFSET_FIELD_I,
    input  wire logic        FRM_OPTIONS_I,
    input  wire logic [31:0] FRM_SRC_ADDR_I,
    input  wire logic [31:0] FRM_DST_ADDR_I,
    input  wire logic        FRM_L4_PARAM_OK_I,
    output logic             MATCH_VALID_O,
    output logic             MATCH_O
);

    // Configuration registers.
    logic [13:0] ctrl_r;
    logic [7:0]  proto_val_r;
    logic [31:0] ip_addr_r [2];
    logic [31:0] ip_mask_r [2];
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic        last_match_r;

    // Bus pipeline state.
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [5:0]  addr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    // The response is always OKAY; a flop keeps this output registered like the others.
    logic        hresp_r;

    // Decoded configuration fields.
    wire logic        cfg_ipv4;
    wire logic [2:0]  cfg_proto;
    wire logic [1:0]  cfg_ttl;
    wire logic [1:0]  cfg_frag;
    wire logic [1:0]  cfg_opt;
    wire logic [1:0]  cfg_addr [2];

    assign cfg_ipv4    = ctrl_r[iam_pkg::CTRL_FTYPE];
    assign cfg_proto   = ctrl_r[iam_pkg::CTRL_PROTO_LO +: 3];
    assign cfg_ttl     = ctrl_r[iam_pkg::CTRL_TTL_LO +: 2];
    assign cfg_frag    = ctrl_r[iam_pkg::CTRL_FRAG_LO +: 2];
    assign cfg_opt     = ctrl_r[iam_pkg::CTRL_OPT_LO +: 2];
    assign cfg_addr[0] = ctrl_r[iam_pkg::CTRL_SRC_LO +: 2];
    assign cfg_addr[1] = ctrl_r[iam_pkg::CTRL_DST_LO +: 2];

    // Protocol filter.
    wire logic proto_ok;
    wire logic is_icmp;
    wire logic is_udp;
    wire logic is_tcp;

    assign is_icmp = FRM_PROTO_I == iam_pkg::PROTO_ICMP;
    assign is_udp  = FRM_PROTO_I == iam_pkg::PROTO_UDP;
    assign is_tcp  = FRM_PROTO_I == iam_pkg::PROTO_TCP;

    // Unused protocol codes never match, so a bad write cannot widen the entry.
    assign proto_ok =
        (cfg_proto == iam_pkg::PM_ANY) ||
        ((cfg_proto == iam_pkg::PM_SPECIFIC) && (FRM_PROTO_I == proto_val_r)) ||
        ((cfg_proto == iam_pkg::PM_ICMP) && is_icmp && FRM_L4_PARAM_OK_I) ||
        ((cfg_proto == iam_pkg::PM_UDP) && is_udp && FRM_L4_PARAM_OK_I) ||
        ((cfg_proto == iam_pkg::PM_TCP) && is_tcp && FRM_L4_PARAM_OK_I);

    // Time-to-live filter.
    wire logic ttl_nonzero;
    wire logic ttl_ok;

    assign ttl_nonzero = FRM_TTL_I != 8'h00;
    assign ttl_ok =
        (cfg_ttl == iam_pkg::TM_ANY) ||
        ((cfg_ttl == iam_pkg::TM_NO) && !ttl_nonzero) ||
        ((cfg_ttl == iam_pkg::TM_YES) && ttl_nonzero);

    // Fragment filter.
    wire logic fragmented;
    wire logic frag_ok;

    assign fragmented = FRM_MORE_FRAG_I || (FRM_FRAGMENT_OFFSET_FIELD_I != 13'h0000);
    assign frag_ok =
        (cfg_frag == iam_pkg::TM_ANY) ||
        ((cfg_frag == iam_pkg::TM_NO) && !fragmented) ||
        ((cfg_frag == iam_pkg::TM_YES) && fragmented);

    // Options filter.
    wire logic opt_ok;

    assign opt_ok =
        (cfg_opt == iam_pkg::TM_ANY) ||
        ((cfg_opt == iam_pkg::TM_NO) && !FRM_OPTIONS_I) ||
        ((cfg_opt == iam_pkg::TM_YES) && FRM_OPTIONS_I);

    // Address filters: index 0 is source, index 1 is destination.
    wire logic [31:0] frm_addr [2];
    wire logic [1:0]  addr_ok;

    assign frm_addr[0] = FRM_SRC_ADDR_I;
    assign frm_addr[1] = FRM_DST_ADDR_I;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_addr
            wire logic host_eq;
            wire logic net_eq;

            assign host_eq = frm_addr[gi] == ip_addr_r[gi];
            assign net_eq  = (frm_addr[gi] & ip_mask_r[gi]) ==
                             (ip_addr_r[gi] & ip_mask_r[gi]);
            assign addr_ok[gi] =
                (cfg_addr[gi] == iam_pkg::AM_ANY) ||
                ((cfg_addr[gi] == iam_pkg::AM_HOST) && host_eq) ||
                ((cfg_addr[gi] == iam_pkg::AM_NETWORK) && net_eq);
        end
    endgenerate

    // Entry verdict.
    wire logic ip_all_ok;
    wire logic entry_match;

    assign ip_all_ok = FRM_IS_IPV4_I && proto_ok && ttl_ok &&
                       frag_ok && opt_ok && (&addr_ok);
    // Without the IPv4 selection the IP settings drop out of the verdict.
    assign entry_match = cfg_ipv4 ? ip_all_ok : 1'b1;

    // Bus address phase decode.
    // Only address bits 7:2 are decoded, so the map repeats every 256 bytes.
    wire logic        bus_take;
    wire logic        bus_wr_take;
    wire logic        bus_rd_take;
    wire logic [7:0]  wr_ofs;
    wire logic [7:0]  rd_ofs;
    wire logic        count_clr;
    wire logic        count_inc;
    wire logic [31:0] rd_mux;

    assign bus_take    = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign bus_wr_take = bus_take && HWRITE_I;
    assign bus_rd_take = bus_take && !HWRITE_I;
    assign wr_ofs      = {addr_r, 2'b00};
    assign rd_ofs      = {addr_r, 2'b00};

    assign count_clr = wr_pend_r && (wr_ofs == iam_pkg::OFS_COUNT);
    assign count_inc = FRM_VALID_I && entry_match;

    // A match in the cycle of a clear is kept: the counter then restarts at one.
    assign count_nxt = count_inc ? (count_clr ? 32'h0000_0001 : count_r + 32'h0000_0001)
                                 : (count_clr ? iam_pkg::COUNT_RST : count_r);

    assign rd_mux =
        (rd_ofs == iam_pkg::OFS_CTRL)      ? {18'h00000, ctrl_r} :
        (rd_ofs == iam_pkg::OFS_PROTO_VAL) ? {24'h000000, proto_val_r} :
        (rd_ofs == iam_pkg::OFS_SRC_ADDR)  ? ip_addr_r[0] :
        (rd_ofs == iam_pkg::OFS_SRC_MASK)  ? ip_mask_r[0] :
        (rd_ofs == iam_pkg::OFS_DST_ADDR)  ? ip_addr_r[1] :
        (rd_ofs == iam_pkg::OFS_DST_MASK)  ? ip_mask_r[1] :
        (rd_ofs == iam_pkg::OFS_COUNT)     ? count_r :
        (rd_ofs == iam_pkg::OFS_STATUS)    ? {31'h00000000, last_match_r} :
                                             32'h0000_0000;

    // Bus pipeline. Reads take one wait state so that a write in the
    // preceding data phase is always visible to them.
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            addr_r      <= 6'h00;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end
        else
        begin
            wr_pend_r <= bus_wr_take;
            hresp_r   <= 1'b0;
            if (bus_take)
            begin
                addr_r <= HADDR_I[iam_pkg::ADDR_MSB:iam_pkg::ADDR_LSB];
            end
            if (bus_rd_take)
            begin
                rd_pend_r   <= 1'b1;
                hreadyout_r <= 1'b0;
            end
            else if (rd_pend_r)
            begin
                rd_pend_r   <= 1'b0;
                hrdata_r    <= rd_mux;
                hreadyout_r <= 1'b1;
            end
        end
    end

    // Configuration writes in the data phase.
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            ctrl_r       <= iam_pkg::CTRL_RST;
            proto_val_r  <= iam_pkg::PROTO_RST;
            ip_addr_r[0] <= iam_pkg::ADDR_RST;
            ip_mask_r[0] <= iam_pkg::MASK_RST;
            ip_addr_r[1] <= iam_pkg::ADDR_RST;
            ip_mask_r[1] <= iam_pkg::MASK_RST;
        end
        else if (wr_pend_r)
        begin
            if (wr_ofs == iam_pkg::OFS_CTRL)
            begin
                ctrl_r <= HWDATA_I[iam_pkg::CTRL_WIDTH-1:0];
            end
            if (wr_ofs == iam_pkg::OFS_PROTO_VAL)
            begin
                proto_val_r <= HWDATA_I[7:0];
            end
            if (wr_ofs == iam_pkg::OFS_SRC_ADDR)
            begin
                ip_addr_r[0] <= HWDATA_I;
            end
            if (wr_ofs == iam_pkg::OFS_SRC_MASK)
            begin
                ip_mask_r[0] <= HWDATA_I;
            end
            if (wr_ofs == iam_pkg::OFS_DST_ADDR)
            begin
                ip_addr_r[1] <= HWDATA_I;
            end
            if (wr_ofs == iam_pkg::OFS_DST_MASK)
            begin
                ip_mask_r[1] <= HWDATA_I;
            end
        end
    end

    // Match result, status and counter.
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            count_r       <= iam_pkg::COUNT_RST;
            last_match_r  <= 1'b0;
            MATCH_VALID_O <= 1'b0;
            MATCH_O       <= 1'b0;
        end
        else
        begin
            count_r       <= count_nxt;
            MATCH_VALID_O <= FRM_VALID_I;
            MATCH_O       <= count_inc;
            if (FRM_VALID_I)
            begin
                last_match_r <= entry_match;
            end
        end
    end

    assign HRDATA_O    = hrdata_r;
    assign HREADYOUT_O = hreadyout_r;
    assign HRESP_O     = hresp_r;

endmodule : iam_matcher

// ---- verification/iam_matcher_sva.sv ----
// Checker for the access control entry matcher.
`timescale 1ns/1ps
module iam_matcher_sva (
    input wire logic        MCLK_I,
    input wire logic        RST_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        HREADY_I,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        FRM_VALID_I,
    input wire logic        FRM_IS_IPV4_I,
    input wire logic [7:0]  FRM_TTL_I,
    input wire logic        FRM_MORE_FRAG_I,
    input wire logic [12:0] FRM_FRAGMENT_OFFSET_FIELD_I,
    input wire logic        FRM_OPTIONS_I,
    input wire logic        MATCH_VALID_O,
    input wire logic        MATCH_O
);
    // Shadow of the control word, so a verdict can be tied to the settings in force.
    logic [13:0] ctl_r;
    logic        wr_r;
    wire         take = HSEL_I && HTRANS_I[1] && HREADY_I;
    wire         fv   = FRM_VALID_I && ctl_r[0];
    always_ff @(posedge MCLK_I)
    begin
        wr_r <= !RST_I && take && HWRITE_I && HADDR_I[7:2] == 6'h00;
        if (RST_I)
            ctl_r <= 14'h0000;
        else if (wr_r && HREADYOUT_O)
            ctl_r <= HWDATA_I[13:0];
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    resp_okay_a: assert property (HRESP_O == 1'b0)
        else $error("response not okay");
    verdict_delay_a: assert property (!$past(RST_I) |-> MATCH_VALID_O == $past(FRM_VALID_I))
        else $error("verdict not one cycle after frame");
    match_qual_a: assert property (MATCH_O |-> MATCH_VALID_O)
        else $error("match without verdict");
    read_wait_a: assert property (take && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
        else $error("read wait state wrong");
    write_nowait_a: assert property (take && HWRITE_I |=> HREADYOUT_O)
        else $error("write stalled");
    type_off_a: assert property (FRM_VALID_I && !ctl_r[0] |=> MATCH_O)
        else $error("frame refused with ip settings off");
    non_ipv4_a: assert property (fv && !FRM_IS_IPV4_I |=> !MATCH_O)
        else $error("non ipv4 frame matched");
    ttl_zero_a: assert property (fv && ctl_r[5:4] == 2'h1 && |FRM_TTL_I |=> !MATCH_O)
        else $error("ttl above zero matched");
    frag_no_a: assert property (fv && ctl_r[7:6] == 2'h1 && (FRM_MORE_FRAG_I || |FRM_FRAGMENT_OFFSET_FIELD_I)
        |=> !MATCH_O) else $error("fragment matched");
    opt_no_a: assert property (fv && ctl_r[9:8] == 2'h1 && FRM_OPTIONS_I |=> !MATCH_O)
        else $error("options frame matched");
    cover property (fv ##1 MATCH_O);
    cover property (take && !HWRITE_I);
    cover property (fv && ctl_r[7:6] == 2'h2 ##1 MATCH_O);
endmodule : iam_matcher_sva

bind iam_matcher iam_matcher_sva chk (.*);

// ---- verification/iam_frame_model.sv ----
// Ingress parser model that emits random IPv4 header fields.
`timescale 1ns/1ps
module iam_frame_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        en_i,
    output logic             valid_o,
    output logic             ipv4_o,
    output logic      [7:0]  proto_o,
    output logic      [7:0]  ttl_o,
    output logic             mf_o,
    output logic      [12:0] off_o,
    output logic             opt_o,
    output logic      [31:0] src_o,
    output logic      [31:0] dst_o,
    output logic             l4_o
);
    localparam logic [7:0] PK [4] = '{8'h01, 8'h06, 8'h11, 8'h00};
    // Fields are redrawn every cycle, so a stale value between frames is never mistaken for data.
    always_ff @(posedge clk_i)
    begin
        valid_o <= !rst_i && en_i && $urandom_range(0, 2) != 0;
        ipv4_o  <= $urandom_range(0, 7) != 0;
        proto_o <= $urandom_range(0, 1) ? PK[$urandom_range(0, 3)] : 8'($urandom);
        ttl_o   <= $urandom_range(0, 1) ? 8'h00 : 8'($urandom);
        mf_o    <= $urandom_range(0, 3) == 0;
        off_o   <= $urandom_range(0, 3) == 0 ? 13'($urandom) : 13'h0000;
        opt_o   <= 1'($urandom);
        src_o   <= {29'h18150000, 3'($urandom)};
        dst_o   <= {29'h01400000, 3'($urandom)};
        l4_o    <= 1'($urandom);
    end
endmodule : iam_frame_model

// ---- verification/tb_ipv4_acl_entry_matcher.sv ----
// Self-checking testbench for the access control entry matcher.
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_ipv4_acl_entry_matcher;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, en = 1'b0, chk = 1'b0, ex = 1'b0, lx = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, base, exp_cnt = 32'h0;
    logic [31:0] cfg [6] = '{default: 32'h0};
    wire  [31:0] hrdata, sa, da;
    wire  [12:0] of;
    wire  [7:0]  pr, tl;
    wire         hready, hresp, mv, mo, fv, ip, mf, op, l4;
    int          num_errors = 0, tests_run = 0;
    iam_matcher dut (
        .MCLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .FRM_VALID_I(fv), .FRM_IS_IPV4_I(ip), .FRM_PROTO_I(pr), .FRM_TTL_I(tl),
        .FRM_MORE_FRAG_I(mf), .FRM_FRAGMENT_OFFSET_FIELD_I(of), .FRM_OPTIONS_I(op), .FRM_SRC_ADDR_I(sa),
        .FRM_DST_ADDR_I(da), .FRM_L4_PARAM_OK_I(l4), .MATCH_VALID_O(mv), .MATCH_O(mo)
    );
    iam_frame_model fm (
        .clk_i(clk), .rst_i(rst), .en_i(en), .valid_o(fv), .ipv4_o(ip), .proto_o(pr), .ttl_o(tl),
        .mf_o(mf), .off_o(of), .opt_o(op), .src_o(sa), .dst_o(da), .l4_o(l4)
    );
    initial forever #2.5 clk = ~clk;
    function automatic logic tri3(logic [1:0] m, logic c);
        return m == 2'h0 || (m == 2'h1 && !c) || (m == 2'h2 && c);
    endfunction : tri3
    function automatic logic adr(logic [1:0] m, logic [31:0] a, logic [31:0] c, logic [31:0] k);
        return m == 2'h0 || (m == 2'h1 && a == c) || (m == 2'h2 && (a & k) == (c & k));
    endfunction : adr
    function automatic logic pred();
        logic [2:0] m;
        logic       p;
        m = cfg[0][3:1];
        p = m == 3'h0 || (m == 3'h1 && pr == cfg[1][7:0]) || (l4 && ((m == 3'h2 && pr == iam_pkg::PROTO_ICMP)
            || (m == 3'h3 && pr == iam_pkg::PROTO_UDP) || (m == 3'h4 && pr == iam_pkg::PROTO_TCP)));
        return !cfg[0][0] || (ip && p && tri3(cfg[0][5:4], tl != 8'h00) && tri3(cfg[0][7:6], mf || of != 13'h0)
            && tri3(cfg[0][9:8], op) && adr(cfg[0][11:10], sa, cfg[2], cfg[3])
            && adr(cfg[0][13:12], da, cfg[4], cfg[5]));
    endfunction : pred
    function automatic logic [1:0] rf();
        return $urandom_range(0, 9) == 0 ? 2'h3 : 2'($urandom_range(0, 2));
    endfunction : rf
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h000000, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("register", e, rd)
    endtask : rdchk
    task automatic run();
        base = exp_cnt;
        en <= 1'b1;
        repeat (40) @(posedge clk);
        en <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(iam_pkg::OFS_COUNT, exp_cnt - base);
        rdchk(iam_pkg::OFS_STATUS, {31'h0, lx});
    endtask : run
    task automatic results();
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    always @(posedge clk)
    begin
        if (chk)
            `CHK("match", ex, mo)
        if (!rst)
            `CHK("valid", chk, mv)
        if (chk)
            exp_cnt <= exp_cnt + 32'(ex);
        if (chk)
            lx <= ex;
        chk <= fv;
        ex  <= pred();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
    initial
    begin
        void'($urandom(70));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        run();
        rdchk(8'h20, 32'h0);
        bus(1'b1, 8'h20, 32'hFFFFFFFF);
        rdchk(8'h20, 32'h0);
        bus(1'b1, iam_pkg::OFS_CTRL, 32'hFFFFFFFF);
        rdchk(iam_pkg::OFS_CTRL, 32'h00003FFF);
        for (int i = 0; i < 60; i++)
        begin
            cfg[0] = {18'h0, rf(), rf(), rf(), rf(), rf(), 3'($urandom_range(0, 7)), $urandom_range(0, 7) != 0};
            if (i == 0)
                cfg[0] = 32'h1;
            cfg[1] = {24'h0, $urandom_range(0, 1) ? 8'h06 : 8'($urandom)};
            cfg[2] = {29'h18150000, 3'($urandom)};
            cfg[3] = 32'hFFFFFFF8 | 32'($urandom_range(0, 7));
            cfg[4] = {29'h01400000, 3'($urandom)};
            cfg[5] = 32'hFFFFFFF8 | 32'($urandom_range(0, 7));
            for (int k = 0; k < 6; k++)
                bus(1'b1, 8'(4 * k), cfg[k]);
            rdchk(iam_pkg::OFS_CTRL, cfg[0]);
            bus(1'b1, iam_pkg::OFS_COUNT, $urandom);
            run();
        end
        results();
    end
endmodule : tb_ipv4_acl_entry_matcher
